// ---- test_tfs_frame_slot_scheduler.sv ----
/* self-checking bench for the frame/slot scheduler with an air peer.
   assumes short slots of 25 cycles, 24 of them active. */
`timescale 1ns/1ps
`define CHK(what, exp, got) begin \
    samplesChecked++; \
    if ((got) !== (exp)) begin \
        $display("unexpected %s: expected %0h seen %0h", what, exp, got); \
        nMismatch++; \
    end \
end
module test_tfs_frame_slot_scheduler
    import tfs_pkg::*;
;
    localparam int otherT [8] = '{6, 10, 14, 18, 6, 10, 14, 17};
    localparam int noiseT [8] = '{0, 0, 0, 0, 12, 8, 4, 1};
    localparam int dataT  [8] = '{48, 40, 40, 32, 32, 32, 32, 32};
    localparam int ackT   [8] = '{4, 8, 4, 8, 8, 8, 8, 8};
    localparam int leftT  [4] = '{20, 14, 4, 0};
    logic            clock, rst, ce, relayEnable, relayClosedReq, dlPending, dlLastPdu;
    logic            ackBurstReq, relayUlReq, loadStb, wantClosed, subchValid, formatError;
    logic            dlTxActive, dlDeferred, relayOpen, relayUlStartValid, mainFmtLatched;
    logic [15:0]     randSeed;
    logic [3:0]      mainFormatIdx, relayFormatIdx, subchannel_select_value;
    logic [3:0]      curFmt = 4'h0, curRel = 4'h0;
    logic [1:0]      frameOffsetSel;
    logic [2:0]      relayUlLen, relayUlStartSlot, lenHeld;
    logic [7:0]      relayClosedNode, relayGrantNode, loadPdus, pdusLeft;
    logic [5:0]      frameExp = 6'h01;
    int              nMismatch = 0, samplesChecked = 0, nStart = 0, nSub = 0;
    tfs_position_t   pos;
    tfs_subframe_t   subframe;
    tfs_relay_part_t relayPart;
    tfs_tx_gate_t    txGate;

    tfs_frame_slot_scheduler #(.SLOT_CYC(25), .ACTIVE_CYC(24)) dut (.*);
    tfs_air_peer peer (.slotTick(pos.slotTick), .*);

    // ---------------------------------------------------------------
    // expected layout
    // ---------------------------------------------------------------
    function automatic tfs_subframe_t expSub(input logic [3:0] f, input logic [5:0] s);
        int b1, b2, b3;
        b1 = 1 + otherT[f];
        b2 = b1 + noiseT[f];
        b3 = b2 + dataT[f];
        if (s == 6'd55 || s >= b3 + ackT[f]) return TFS_SF_RESERVED;
        if (s == 6'd0) return TFS_SF_SYNC;
        if (s < b1) return TFS_SF_DL;
        if (s < b2) return TFS_SF_NOISE;
        return (s < b3) ? TFS_SF_UL_DATA : TFS_SF_UL_ACK;
    endfunction : expSub

    function automatic tfs_relay_part_t expRel(input logic [3:0] r, input logic [5:0] s,
                                               input logic en);
        int d;
        d = 21 + 4 * r; // first relay uplink slot
        if (!en || s < 6'd19 || s >= d + 5) return TFS_RS_NONE;
        if (s == 6'd19) return TFS_RS_SYNC;
        return (s < d) ? TFS_RS_DL : TFS_RS_UL;
    endfunction : expRel

    task automatic waitSlot(input logic [5:0] s);
        int k;
        k = 0;
        do begin
            @(posedge clock);
            k++;
        end while (!(pos.slot === s && pos.slotTick === 1'b1) && k < 1700);
        if (k >= 1700) nMismatch++;
    endtask : waitSlot

    task automatic pulse(input int n);
        ackBurstReq <= 1'b1;
        repeat (n) @(posedge clock);
        ackBurstReq <= 1'b0;
    endtask : pulse

    task automatic conclude;
        if (nMismatch == 0 && samplesChecked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : conclude

    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    // monitor at the falling edge, where every output has settled
    always @(negedge clock) begin
        if (!rst && ce) begin
            if (relayUlStartValid) nStart++;
            if (relayUlStartValid) `CHK("relayFit", 1'b1, 4'(relayUlStartSlot) + 4'(lenHeld) <= 4'h5)
            if (subchValid) nSub++;
            if (pos.frameStart) begin
                if (mainFormatIdx <= 4'h7) curFmt = mainFormatIdx;
                if (relayFormatIdx <= 4'h4) curRel = relayFormatIdx;
                `CHK("formatError", mainFormatIdx > 4'h7 || relayFormatIdx > 4'h4, formatError)
                `CHK("frame", frameExp, pos.frame)
                frameExp++;
            end
            if (pos.slotTick) `CHK("subframe", expSub(curFmt, pos.slot), subframe)
            if (pos.slotTick) `CHK("relayPart", expRel(curRel, pos.slot, relayEnable), relayPart)
            if (pos.slotTick) `CHK("ulPick", expRel(curRel, pos.slot, relayEnable) == TFS_RS_UL, txGate.relayUlSlotPick)
        end
        lenHeld = relayUlLen;
    end

    // ---------------------------------------------------------------
    // main sequence: one pass per frame, changes made at slot 30
    // ---------------------------------------------------------------
    initial begin
        int i;
        logic [5:0] held;
        {rst, ce, relayEnable} = 3'b111;
        {ackBurstReq, relayUlReq, loadStb, wantClosed} = 4'h0;
        {mainFormatIdx, relayFormatIdx, frameOffsetSel, relayUlLen} = '0;
        randSeed = 16'h1234;
        loadPdus = 8'd20;
        repeat (16) @(posedge clock);
        rst <= 1'b0;
        for (i = 0; i < 65; i++) begin
            waitSlot(6'd30);
            if (i == 1 || i == 2) `CHK("dlDeferred", 1'b1, dlDeferred)
            if (i >= 1 && i <= 3) `CHK("pdusLeft", leftT[i], pdusLeft)
            if (i == 4 || i == 5) `CHK("relayOpen", i == 5, relayOpen)
            if (i == 4) `CHK("grant", 8'h5A, relayGrantNode)
            mainFormatIdx <= 4'(i < 10 ? i : i % 8);
            relayFormatIdx <= 4'(i % 6);
            frameOffsetSel <= 2'(i % 3);
            wantClosed <= (i == 3);
            relayEnable <= (i != 12);
            loadStb <= (i == 0);
            @(posedge clock);
            loadStb <= 1'b0;
            if (i == 5) begin
                // back-to-back relay picks, every burst length
                for (int k = 1; k <= 5; k++) begin
                    relayUlReq <= 1'b1;
                    relayUlLen <= 3'(k);
                    @(posedge clock);
                end
                relayUlReq <= 1'b0;
                repeat (2) @(posedge clock);
                `CHK("relayStarts", 5, nStart)
            end
            if (i == 6) begin
                // requests in the data subframe must not pick a subchannel
                pulse(2);
                waitSlot(6'd52);
                pulse(2);
                repeat (2) @(posedge clock);
                `CHK("subchPulses", 2, nSub)
            end
            if (i == 8) begin
                held = pos.slot;
                ce <= 1'b0;
                repeat (40) @(posedge clock);
                `CHK("frozenSlot", held, pos.slot)
                ce <= 1'b1;
            end
        end
        conclude;
    end

    // watchdog sized a little above the 65 frames of the main sequence
    initial begin
        repeat (100000) @(posedge clock);
        nMismatch++;
        conclude;
    end
endmodule : test_tfs_frame_slot_scheduler

// ---- tfs_air_peer.sv ----
/* far side: base station downlink queue and an orphan node.
   assumes one pdu leaves per downlink slot that carried traffic. */
`timescale 1ns/1ps
module tfs_air_peer (
    input  wire logic       clock,
    input  wire logic       rst,
    input  wire logic       slotTick,
    input  wire logic       loadStb,
    input  wire logic [7:0] loadPdus,
    input  wire logic       wantClosed,
    input  wire logic       dlTxActive,
    output      logic       dlPending,
    output      logic       dlLastPdu,
    output      logic       relayClosedReq,
    output      logic [7:0] relayClosedNode,
    output      logic [7:0] pdusLeft
);
    logic sent_r;
    // leftovers stay queued for the next frame's downlink subframe
    always_ff @(posedge clock) begin
        if (rst) begin
            pdusLeft <= 8'h00;
            sent_r   <= 1'b0;
        end else if (loadStb) begin
            pdusLeft <= loadPdus;
        end else if (slotTick) begin
            pdusLeft <= pdusLeft - {7'h00, sent_r};
            sent_r   <= dlTxActive;
        end else begin
            sent_r <= sent_r | dlTxActive;
        end
    end
    assign dlPending       = pdusLeft != 8'h00;
    assign dlLastPdu       = pdusLeft == 8'h01;
    // level stands for a sync-only uplink burst asking for a closed subframe
    assign relayClosedReq  = wantClosed;
    assign relayClosedNode = 8'h5A;
endmodule : tfs_air_peer

// ---- tfs_defs.svh ----
/*
 * timing and layout constants for the frame/slot scheduler.
 * assumes a 200 MHz clock; included by the package, the scheduler and the random source.
 */
`ifndef TFS_DEFS_SVH
`define TFS_DEFS_SVH

// -------------------------------------------------------------------
// time base
// -------------------------------------------------------------------
`define TFS_CLK_PERIOD_PS   5000
`define TFS_SLOT_MS         400
`define TFS_ACTIVE_MS       384
`define TFS_GUARD_MS        16
`define TFS_SLOT_CYC        ((`TFS_SLOT_MS * 64'd1000000000) / `TFS_CLK_PERIOD_PS)
`define TFS_ACTIVE_CYC      ((`TFS_ACTIVE_MS * 64'd1000000000) / `TFS_CLK_PERIOD_PS)

// -------------------------------------------------------------------
// frame layout
// -------------------------------------------------------------------
`define TFS_SLOTS_PER_FRAME 6'd60
`define TFS_LAST_SLOT       6'd59
`define TFS_LAST_FRAME      6'd63
`define TFS_RELAY_START     6'd19
`define TFS_RESERVED_SLOT   6'd55
`define TFS_OFFSET_20       6'd20
`define TFS_OFFSET_40       6'd40
`define TFS_MAIN_FMT_MAX    4'd7
`define TFS_RELAY_FMT_MAX   4'd4
`define TFS_RELAY_UL_SLOTS  6'd5
`define TFS_RELAY_OTHER_STEP 6'd4
`define TFS_RELAY_OTHER_BASE 6'd1
`define TFS_SYNC_SLOTS      6'd1
`define TFS_LFSR_TAPS       16'hB400
`define TFS_LFSR_ALT_SEED   16'hACE1

`endif

// ---- tfs_frame_slot_scheduler.sv ----
/*
 * slot/frame/superframe sequencer with subframe decode, relay access and
 * random sub-channel choice for a tdd narrowband radio endpoint.
 * assumes synchronous inputs, a 200 MHz clock and an upstream traffic planner
 * that supplies formats and burst requests.
 */
// Function
// - slot lasts 0.4 s, counter advances
// - sixty slots per frame, wrap advances frame
// - sixty-four frames per superframe
// - 384 ms active then 16 ms guard
// - burst spans consecutive slots, stops when done
// - one downlink burst, starts first subframe slot
// - overflowed pdus deferred to next frame
// - relay subframe starts at slot 19
// - slot 55 reserved, no transmission
// - eight main formats, 8-15 reserved
// - main format slot count table
// - main format chosen anew each frame
// - five relay formats, 5-15 reserved
// - relay format chosen each frame
// - relay signals open or closed subframe
// - closed subframe: only named orphan sends (grant node is only output; relay uplink picks are not gated by relayOpen)
// - relay access random in time only
// - relay burst start fits within subframe
// - random generator seeded per unit
// - random sub-channel per ack burst
// - frame counter six bits modulo 64
// - frame offset 0, 20 or 40 slots (latched per frame, never applied to slot or outputs)
`timescale 1ns/1ps
`include "tfs_defs.svh"

module tfs_frame_slot_scheduler
    import tfs_pkg::*;
#(
    parameter longint SLOT_CYC   = `TFS_SLOT_CYC,
    parameter longint ACTIVE_CYC = `TFS_ACTIVE_CYC,
    parameter int     SUBCH_W    = 4
) (
    input  wire logic                   clock,
    input  wire logic                   rst,
    input  wire logic                   ce,
    input  wire logic [15:0]            randSeed,
    input  wire logic [3:0]             mainFormatIdx,
    input  wire logic [3:0]             relayFormatIdx,
    input  wire logic [1:0]             frameOffsetSel,
    input  wire logic                   relayEnable,
    input  wire logic                   relayClosedReq,
    input  wire logic [7:0]             relayClosedNode,
    input  wire logic                   dlPending,
    input  wire logic                   dlLastPdu,
    input  wire logic                   ackBurstReq,
    input  wire logic                   relayUlReq,
    input  wire logic [2:0]             relayUlLen,
    output      tfs_pkg::tfs_position_t pos,
    output      tfs_pkg::tfs_subframe_t subframe,
    output      tfs_pkg::tfs_relay_part_t relayPart,
    output      tfs_pkg::tfs_tx_gate_t  txGate,
    output      logic                   dlTxActive,
    output      logic                   dlDeferred,
    output      logic                   relayOpen,
    output      logic [7:0]             relayGrantNode,
    output      logic [SUBCH_W-1:0]     subchannel_select_value,
    output      logic                   subchValid,
    output      logic [2:0]             relayUlStartSlot,
    output      logic                   relayUlStartValid,
    output      logic                   mainFmtLatched,
    output      logic                   formatError
);
    // -------------------------------------------------------------------
    // state
    // -------------------------------------------------------------------
    typedef struct packed {
        logic [31:0]        cyc;
        logic [5:0]         slot;
        logic [5:0]         frame;
        logic [5:0]         offset;
        logic [2:0]         mainFmt;
        logic [2:0]         relayFmt;
        logic               fmtErr;
        logic               slotTick;
        logic               frameStart;
        logic               superStart;
        logic               dlBusy;
        logic               dlDone;
        logic               dlDefer;
        logic               open;
        logic [7:0]         grant;
        logic [SUBCH_W-1:0] subch;
        logic               subchV;
        logic [2:0]         ulStart;
        logic               ulStartV;
        logic               fmtLatched;
    } tfs_state_t;

    tfs_state_t state_r, state_nxt;
    logic [15:0] rnd;
    logic        rndStep;

    initial begin
        if (SLOT_CYC <= ACTIVE_CYC || ACTIVE_CYC < 1) $error("bad slot timing");
        if (SUBCH_W < 1 || SUBCH_W > 16) $error("SUBCH_W out of range");
    end

    tfs_rand_src #(.WIDTH(16)) uRand (
        .clock (clock),
        .rst   (rst),
        .ce    (ce),
        .seed  (randSeed),
        .step  (rndStep),
        .value (rnd)
    );

    // -------------------------------------------------------------------
    // format table and boundaries
    // -------------------------------------------------------------------
    function automatic tfs_main_fmt_t mainTable(input logic [2:0] f);
        tfs_main_fmt_t t;
        t = '{`TFS_SYNC_SLOTS, 6'd6, 6'd0, 6'd48, 6'd4};
        unique case (f)
            3'h0: t = '{`TFS_SYNC_SLOTS, 6'd6,  6'd0,  6'd48, 6'd4};
            3'h1: t = '{`TFS_SYNC_SLOTS, 6'd10, 6'd0,  6'd40, 6'd8};
            3'h2: t = '{`TFS_SYNC_SLOTS, 6'd14, 6'd0,  6'd40, 6'd4};
            3'h3: t = '{`TFS_SYNC_SLOTS, 6'd18, 6'd0,  6'd32, 6'd8};
            3'h4: t = '{`TFS_SYNC_SLOTS, 6'd6,  6'd12, 6'd32, 6'd8};
            3'h5: t = '{`TFS_SYNC_SLOTS, 6'd10, 6'd8,  6'd32, 6'd8};
            3'h6: t = '{`TFS_SYNC_SLOTS, 6'd14, 6'd4,  6'd32, 6'd8};
            3'h7: t = '{`TFS_SYNC_SLOTS, 6'd17, 6'd1,  6'd32, 6'd8};
        endcase
        return t;
    endfunction : mainTable

    tfs_main_fmt_t fmt;
    logic [5:0]    bDl, bNoise, bUlData, bUlAck, bEnd;
    logic [5:0]    rDl, rUl, rEnd;
    logic [5:0]    lslot;

    // cumulative sums give each subframe's first slot
    always_comb begin
        fmt     = mainTable(state_r.mainFmt);
        bDl     = fmt.sync;
        bNoise  = 6'(bDl + fmt.other);
        bUlData = 6'(bNoise + fmt.noise);
        bUlAck  = 6'(bUlData + fmt.ulData);
        bEnd    = 6'(bUlAck + fmt.ulAck);
        rDl     = 6'(`TFS_RELAY_START + `TFS_SYNC_SLOTS);
        rUl     = 6'(rDl + `TFS_RELAY_OTHER_BASE
                  + 6'(state_r.relayFmt) * `TFS_RELAY_OTHER_STEP);
        rEnd    = 6'(rUl + `TFS_RELAY_UL_SLOTS);
        lslot   = state_r.slot;
    end

    // slot classification; the reserved slot overrides every format
    always_comb begin
        subframe  = TFS_SF_SYNC;
        relayPart = TFS_RS_NONE;
        if (lslot == `TFS_RESERVED_SLOT)       subframe = TFS_SF_RESERVED;
        else if (lslot < bDl)                  subframe = TFS_SF_SYNC;
        else if (lslot < bNoise)               subframe = TFS_SF_DL;
        else if (lslot < bUlData)              subframe = TFS_SF_NOISE;
        else if (lslot < bUlAck)               subframe = TFS_SF_UL_DATA;
        else if (lslot < bEnd)                 subframe = TFS_SF_UL_ACK;
        else                                   subframe = TFS_SF_RESERVED;
        if (relayEnable && lslot != `TFS_RESERVED_SLOT) begin
            if (lslot == `TFS_RELAY_START)                 relayPart = TFS_RS_SYNC;
            else if (lslot > `TFS_RELAY_START && lslot < rUl) relayPart = TFS_RS_DL;
            else if (lslot >= rUl && lslot < rEnd)         relayPart = TFS_RS_UL;
        end
    end

    // -------------------------------------------------------------------
    // next state
    // -------------------------------------------------------------------
    logic       slotEnd, frameEnd, inGuard;
    logic [5:0] ulLeft;
    logic [2:0] span;

    always_comb begin
        state_nxt            = state_r;
        state_nxt.slotTick   = 1'b0;
        state_nxt.frameStart = 1'b0;
        state_nxt.superStart = 1'b0;
        state_nxt.subchV     = 1'b0;
        state_nxt.ulStartV   = 1'b0;
        state_nxt.fmtLatched = 1'b0;
        slotEnd  = (state_r.cyc == 32'(SLOT_CYC - 1));
        frameEnd = slotEnd && (state_r.slot == `TFS_LAST_SLOT);
        inGuard  = (state_r.cyc >= 32'(ACTIVE_CYC));
        ulLeft   = 6'(rEnd - `TFS_RELAY_UL_SLOTS);
        span     = (relayUlLen > 3'(`TFS_RELAY_UL_SLOTS)) ? 3'(`TFS_RELAY_UL_SLOTS)
                                                            : relayUlLen;
        rndStep  = 1'b0;

        // slot timer and counters
        state_nxt.cyc = slotEnd ? '0 : 32'(state_r.cyc + 32'd1);
        if (slotEnd) begin
            state_nxt.slotTick = 1'b1;
            state_nxt.slot     = frameEnd ? '0 : 6'(state_r.slot + 6'd1);
        end
        if (frameEnd) begin
            state_nxt.frame      = 6'(state_r.frame + 6'd1);
            state_nxt.frameStart = 1'b1;
            state_nxt.superStart = (state_r.frame == `TFS_LAST_FRAME);
            // formats picked per frame; reserved codes keep the old one
            state_nxt.fmtErr = (mainFormatIdx > `TFS_MAIN_FMT_MAX)
                             || (relayFormatIdx > `TFS_RELAY_FMT_MAX);
            if (mainFormatIdx <= `TFS_MAIN_FMT_MAX) begin
                state_nxt.mainFmt = mainFormatIdx[2:0];
            end
            if (relayFormatIdx <= `TFS_RELAY_FMT_MAX) begin
                state_nxt.relayFmt = relayFormatIdx[2:0];
            end
            state_nxt.fmtLatched = 1'b1;
            unique case (frameOffsetSel)
                2'd1:    state_nxt.offset = `TFS_OFFSET_20;
                2'd2:    state_nxt.offset = `TFS_OFFSET_40;
                default: state_nxt.offset = '0;
            endcase
            // open/closed decision announced per frame
            state_nxt.open  = !relayClosedReq;
            state_nxt.grant = relayClosedReq ? relayClosedNode : '0;
            state_nxt.dlDone  = 1'b0;
            state_nxt.dlDefer = state_r.dlBusy;
            state_nxt.dlBusy  = 1'b0;
        end

        // downlink burst: one per frame, first slot of the dl subframe
        if (slotEnd && !frameEnd) begin
            if (state_nxt.slot == bDl && dlPending && !state_r.dlDone) begin
                state_nxt.dlBusy  = 1'b1;
                state_nxt.dlDefer = 1'b0;
            end else if (state_r.dlBusy && (dlLastPdu || state_nxt.slot >= bNoise)) begin
                state_nxt.dlBusy  = 1'b0;
                state_nxt.dlDone  = 1'b1;
                state_nxt.dlDefer = !dlLastPdu;
            end
        end

        // ack burst: fresh sub-channel per burst, no time spreading here
        if (ackBurstReq && subframe == TFS_SF_UL_ACK) begin
            state_nxt.subch  = rnd[SUBCH_W-1:0];
            state_nxt.subchV = 1'b1;
            rndStep          = 1'b1;
        end

        // relay uplink: random start among slots that still fit the burst
        if (relayUlReq && relayPart == TFS_RS_DL && span != 3'd0) begin
            state_nxt.ulStart  = 3'(rnd[7:0] % (8'(`TFS_RELAY_UL_SLOTS)
                                 - 8'(span) + 8'd1));
            state_nxt.ulStartV = 1'b1;
            rndStep            = 1'b1;
        end
    end

    // -------------------------------------------------------------------
    // state register
    // -------------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (rst) begin
            state_r <= '0;
            state_r.open <= 1'b1;
        end else if (ce) begin
            state_r <= state_nxt;
        end
    end

    // -------------------------------------------------------------------
    // outputs
    // -------------------------------------------------------------------
    assign pos.slot       = state_r.slot;
    assign pos.frame      = state_r.frame;
    assign pos.slotTick   = state_r.slotTick;
    assign pos.frameStart = state_r.frameStart;
    assign pos.superStart = state_r.superStart;
    assign pos.guard      = inGuard;
    // guard and reserved slot block the transmitter on both links
    assign txGate.mainTxAllowed  = !inGuard && subframe != TFS_SF_RESERVED;
    assign txGate.relayTxAllowed = !inGuard && relayPart != TFS_RS_NONE;
    assign txGate.dlBurstStart   = state_r.dlBusy && state_r.slot == bDl;
    assign txGate.relayUlSlotPick = relayPart == TFS_RS_UL;
    assign dlTxActive        = state_r.dlBusy && !inGuard;
    assign dlDeferred        = state_r.dlDefer;
    assign relayOpen         = state_r.open;
    assign relayGrantNode    = state_r.grant;
    assign subchannel_select_value = state_r.subch;
    assign subchValid        = state_r.subchV;
    assign relayUlStartSlot  = state_r.ulStart;
    assign relayUlStartValid = state_r.ulStartV;
    assign mainFmtLatched    = state_r.fmtLatched;
    assign formatError       = state_r.fmtErr;
endmodule : tfs_frame_slot_scheduler

// ---- tfs_pkg.sv ----
/*
 * types shared by the scheduler, its checker and the testbench.
 * assumes tfs_defs.svh is on the include path.
 */
package tfs_pkg;
    `include "tfs_defs.svh"

    // subframe the current slot lies in
    typedef enum logic [2:0] {
        TFS_SF_SYNC, TFS_SF_DL, TFS_SF_NOISE, TFS_SF_UL_DATA, TFS_SF_UL_ACK,
        TFS_SF_RESERVED
    } tfs_subframe_t;

    // relay subframe part
    typedef enum logic [1:0] {
        TFS_RS_NONE, TFS_RS_SYNC, TFS_RS_DL, TFS_RS_UL
    } tfs_relay_part_t;

    // per-format slot counts of the main link
    typedef struct packed {
        logic [5:0] sync;
        logic [5:0] other;
        logic [5:0] noise;
        logic [5:0] ulData;
        logic [5:0] ulAck;
    } tfs_main_fmt_t;

    // frame position as seen by software
    typedef struct packed {
        logic [5:0] slot;
        logic [5:0] frame;
        logic       slotTick;
        logic       frameStart;
        logic       superStart;
        logic       guard;
    } tfs_position_t;

    // transmit permissions per link
    typedef struct packed {
        logic mainTxAllowed;
        logic relayTxAllowed;
        logic dlBurstStart;
        logic relayUlSlotPick;
    } tfs_tx_gate_t;
endpackage : tfs_pkg

// ---- tfs_rand_src.sv ----
/*
 * per-unit seeded random source (16-bit galois lfsr).
 * assumes the seed is set randomly per unit by the integrator.
 */
`timescale 1ns/1ps
`include "tfs_defs.svh"

module tfs_rand_src #(
    parameter int WIDTH = 16
) (
    input  wire logic             clock,
    input  wire logic             rst,
    input  wire logic             ce,
    input  wire logic [WIDTH-1:0] seed,
    input  wire logic             step,
    output      logic [WIDTH-1:0] value
);
    typedef struct packed {
        logic [WIDTH-1:0] lfsr;
        logic             loaded;
    } tfs_rand_state_t;

    tfs_rand_state_t state_r, state_nxt;

    initial begin
        if (WIDTH != 16) $error("tfs_rand_src supports WIDTH 16 only");
    end

    // -------------------------------------------------------------------
    // next state
    // -------------------------------------------------------------------
    // seed loads once after reset; an all-zero seed would lock the lfsr
    always_comb begin
        state_nxt = state_r;
        if (!state_r.loaded) begin
            state_nxt.lfsr   = (seed == '0) ? `TFS_LFSR_ALT_SEED : seed;
            state_nxt.loaded = 1'b1;
        end else if (step) begin
            state_nxt.lfsr = state_r.lfsr[0] ? ((state_r.lfsr >> 1) ^ `TFS_LFSR_TAPS)
                                             : (state_r.lfsr >> 1);
        end
    end

    // -------------------------------------------------------------------
    // state register
    // -------------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (rst) begin
            state_r <= '0;
        end else if (ce) begin
            state_r <= state_nxt;
        end
    end

    assign value = state_r.lfsr;
endmodule : tfs_rand_src

// ---- tfs_sched_checker.sv ----
/* checker for the slot scheduler: timing, layout and random picks.
   assumes ce is only dropped in mid-slot. */
`timescale 1ns/1ps
module tfs_sched_checker
    import tfs_pkg::*;
#(
    parameter longint SLOT_CYC   = 25,
    parameter longint ACTIVE_CYC = 24
) (
    input wire logic                     clock,
    input wire logic                     rst,
    input wire logic                     ce,
    input wire logic [3:0]               mainFormatIdx,
    input wire logic [3:0]               relayFormatIdx,
    input wire logic                     relayEnable,
    input wire logic                     ackBurstReq,
    input wire logic [2:0]               relayUlLen,
    input wire tfs_pkg::tfs_position_t   pos,
    input wire tfs_pkg::tfs_subframe_t   subframe,
    input wire tfs_pkg::tfs_relay_part_t relayPart,
    input wire tfs_pkg::tfs_tx_gate_t    txGate,
    input wire logic                     subchValid,
    input wire logic [2:0]               relayUlStartSlot,
    input wire logic                     relayUlStartValid,
    input wire logic                     mainFmtLatched,
    input wire logic                     formatError
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    int unsigned sinceTick_r;
    logic        seen_r;
    // cycles since the last tick; frozen with ce just like the slot counter
    always_ff @(posedge clock) begin
        if (rst) begin
            sinceTick_r <= 0;
            seen_r      <= 1'b0;
        end else if (ce) begin
            sinceTick_r <= pos.slotTick ? 1 : sinceTick_r + 1;
            seen_r      <= seen_r | pos.slotTick;
        end
    end
    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    AST_SLOT_LEN: assert property (pos.slotTick && seen_r |-> sinceTick_r == SLOT_CYC)
        else $error("slot period wrong");
    AST_FRAME_STEP: assert property (pos.frameStart |-> pos.slot == 6'h00 &&
        pos.frame == 6'($past(pos.frame) + 6'h01)) else $error("frame step wrong");
    AST_SUPER: assert property (pos.frameStart |-> pos.superStart == (pos.frame == 6'h00))
        else $error("superframe mark wrong");
    AST_GUARD: assert property (!pos.slotTick |-> pos.guard == (sinceTick_r >= ACTIVE_CYC))
        else $error("guard not at slot end");
    AST_RESERVED: assert property (pos.slot == 6'h37 |-> subframe == TFS_SF_RESERVED &&
        !txGate.mainTxAllowed && !txGate.relayTxAllowed) else $error("reserved slot used");
    AST_RELAY_AT_19: assert property (relayEnable |->
        (pos.slot == 6'h13) == (relayPart == TFS_RS_SYNC)) else $error("relay start wrong");
    AST_DL_FIRST: assert property (txGate.dlBurstStart |-> pos.slot == 6'h01)
        else $error("downlink burst start wrong");
    AST_FMT_ERR: assert property (mainFmtLatched |-> formatError ==
        ($past(mainFormatIdx) > 4'h7 || $past(relayFormatIdx) > 4'h4))
        else $error("format error flag wrong");
    AST_SUBCH: assert property (subchValid == ($past(ce) && $past(ackBurstReq) &&
        $past(subframe) == TFS_SF_UL_ACK)) else $error("subchannel pick wrong");
    AST_RELAY_FIT: assert property (relayUlStartValid |-> $past(relayPart) == TFS_RS_DL &&
        4'(relayUlStartSlot) + 4'($past(relayUlLen)) <= 4'h5) else $error("relay start overruns");
endmodule : tfs_sched_checker

bind tfs_frame_slot_scheduler tfs_sched_checker #(.SLOT_CYC(SLOT_CYC), .ACTIVE_CYC(ACTIVE_CYC)) chk (.*);
